// [usfc_top.sv]
// receive side of the serial transceiver: shifter, flow control, dma fifo
// Notes on behaviour
// - handshaking mode: request-to-send goes high when the dma receive buffer fills.
// - force-high command drives request-to-send high in any mode.
// - force-low command drives request-to-send low so the peer may resume.
// - spi slave: more clocked bits than character length raises the error flag.
// - receiver soft reset then reconfiguration restores reception after transmit.
`timescale 1ns/1ps
`include "usfc_consts.svh"
module usfc_top #(
   parameter int CHAR_BITS = `USFC_CHAR_BITS,
   parameter int FIFO_DEPTH = `USFC_FIFO_DEPTH
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [1:0] mode_config_reg_i,
   input wire logic rx_enable_cmd_i,
   input wire logic rx_soft_reset_cmd_i,
   input wire logic rts_force_high_cmd_i,
   input wire logic rts_force_low_cmd_i,
   input wire logic len_err_clear_i,
   input wire logic serial_clk_i,
   input wire logic serial_data_i,
   input wire logic spi_sel_n_i,
   input wire logic dma_buf_full_i,
   input wire logic dma_buf_avail_i,
   input wire logic dma_ready_i,
   output logic [CHAR_BITS-1:0] dma_data_o,
   output logic dma_valid_o,
   output logic rts_o,
   output logic rx_enabled_o,
   output logic len_err_o
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
   logic data_s1_q, data_s2_q;
   logic sel_s1_q, sel_s2_q, sel_s3_q;

   // external clock is only sampled: needs at least nine core clocks per period
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_s1_q <= `USFC_SYNC_RST;
         sclk_s2_q <= `USFC_SYNC_RST;
         sclk_s3_q <= `USFC_SYNC_RST;
         data_s1_q <= `USFC_SYNC_RST;
         data_s2_q <= `USFC_SYNC_RST;
         sel_s1_q <= `USFC_CS_IDLE;
         sel_s2_q <= `USFC_CS_IDLE;
         sel_s3_q <= `USFC_CS_IDLE;
      end else begin
         sclk_s1_q <= serial_clk_i;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         data_s1_q <= serial_data_i;
         data_s2_q <= data_s1_q;
         sel_s1_q <= spi_sel_n_i;
         sel_s2_q <= sel_s1_q;
         sel_s3_q <= sel_s2_q;
      end
   end

   // ************************************************************
   // decode
   // ************************************************************
   wire usfc_pkg::usfc_mode_t mode = usfc_pkg::usfc_mode_t'(mode_config_reg_i);
   wire is_spi = (mode == usfc_pkg::USFC_MODE_SPI_SLAVE);
   wire is_hwhs = (mode == usfc_pkg::USFC_MODE_HWHS);
   wire sclk_rise = sclk_s2_q && !sclk_s3_q;
   wire sel_active = !sel_s2_q;
   wire sel_release = sel_s2_q && !sel_s3_q;
   logic [`USFC_CNT_W-1:0] cnt_q, cnt_d;
   logic [CHAR_BITS-1:0] shreg_q;
   logic rx_en_q, err_q, rts_q;
   logic push_q;
   logic [CHAR_BITS-1:0] push_data_q;
   wire bit_take = rx_en_q && sclk_rise && (!is_spi || sel_active);
   wire last_bit = (cnt_q == `USFC_CNT_W'(CHAR_BITS - 1));
   wire extra_bit = is_spi && (cnt_q >= `USFC_CNT_W'(CHAR_BITS));
   wire char_done = bit_take && last_bit;
   wire fifo_full;
   wire fifo_ready;
   wire buf_full = dma_buf_full_i || fifo_full;

   always_comb begin
      cnt_d = cnt_q;
      if (is_spi && sel_release) begin
         cnt_d = '0;
      end else if (bit_take) begin
         if (extra_bit) begin
            cnt_d = cnt_q;
         end else if (char_done && !is_spi) begin
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   // ************************************************************
   // receiver state
   // ************************************************************
   // soft reset wipes shifter and enable; software rewrites mode then enables
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         shreg_q <= '0;
         rx_en_q <= `USFC_RXEN_RST;
         push_q <= 1'b0;
         push_data_q <= '0;
      end else if (rx_soft_reset_cmd_i) begin
         cnt_q <= '0;
         shreg_q <= '0;
         rx_en_q <= 1'b0;
         push_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         if (rx_enable_cmd_i) rx_en_q <= 1'b1;
         if (bit_take && !extra_bit) shreg_q <= {data_s2_q, shreg_q[CHAR_BITS-1:1]};
         // a char with no room is dropped; handshaking mode only raises rts to ask the peer to wait
         push_q <= char_done && fifo_ready;
         if (char_done) push_data_q <= {data_s2_q, shreg_q[CHAR_BITS-1:1]};
      end
   end

   // ************************************************************
   // length error and flow control
   // ************************************************************
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         err_q <= `USFC_ERR_RST;
      end else if (bit_take && extra_bit) begin
         err_q <= 1'b1; // set beats clear
      end else if (len_err_clear_i || rx_soft_reset_cmd_i) begin
         err_q <= 1'b0;
      end
   end

   // force-high beats force-low when both arrive together
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rts_q <= `USFC_RTS_RST;
      end else if (rts_force_high_cmd_i) begin
         rts_q <= 1'b1;
      end else if (rts_force_low_cmd_i) begin
         rts_q <= 1'b0;
      end else if (is_hwhs && buf_full) begin
         rts_q <= 1'b1;
      end else if (is_hwhs && dma_buf_avail_i) begin
         rts_q <= 1'b0;
      end
   end

   assign rts_o = rts_q;
   assign rx_enabled_o = rx_en_q;
   assign len_err_o = err_q;

   // ************************************************************
   // dma fifo
   // ************************************************************
   usfc_fifo #(.W(CHAR_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .flush_i(rx_soft_reset_cmd_i),
      .in_valid_i(push_q),
      .in_ready_o(fifo_ready),
      .in_data_i(push_data_q),
      .out_valid_o(dma_valid_o),
      .out_ready_i(dma_ready_i),
      .out_data_o(dma_data_o),
      .full_o(fifo_full)
   );

   // ************************************************************
   // assertions
   // ************************************************************
   a_rts_full_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (is_hwhs && buf_full && !rts_force_low_cmd_i) |=> rts_o)
      else $error("rts low after buffer full in handshaking mode");
   a_rts_force_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      rts_force_high_cmd_i |=> rts_o)
      else $error("rts not high after force-high command");
   a_rts_force_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (rts_force_low_cmd_i && !rts_force_high_cmd_i) |=> !rts_o)
      else $error("rts not low after force-low command");
   a_rts_avail_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (is_hwhs && dma_buf_avail_i && !buf_full && !rts_force_high_cmd_i) |=> !rts_o)
      else $error("rts not low after new dma buffer");
   a_spi_len_err: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (is_spi && rx_en_q && sel_active && sclk_rise && cnt_q == `USFC_CNT_W'(CHAR_BITS)
       && !rx_soft_reset_cmd_i) |=> len_err_o)
      else $error("over-long spi frame not flagged");
   a_err_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (len_err_o && !len_err_clear_i && !rx_soft_reset_cmd_i) |=> len_err_o)
      else $error("length error dropped without clear");
   a_soft_rst_rx: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      rx_soft_reset_cmd_i |=> (!rx_enabled_o && cnt_q == '0 && !dma_valid_o))
      else $error("soft reset did not clear receiver");
   a_rx_reenable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (rx_enable_cmd_i && !rx_soft_reset_cmd_i) |=> rx_enabled_o)
      else $error("receiver not enabled after enable command");
endmodule

// [usfc_consts.svh]
// constants for the serial receive flow-control block
`ifndef USFC_CONSTS_SVH
`define USFC_CONSTS_SVH
`define USFC_CHAR_BITS 8
`define USFC_FIFO_DEPTH 4
`define USFC_CNT_W 4
`define USFC_RTS_RST 1'b1
`define USFC_RXEN_RST 1'b0
`define USFC_ERR_RST 1'b0
`define USFC_SYNC_RST 1'b0
`define USFC_CS_IDLE 1'b1
`define USFC_MIN_CLK_RATIO 9
`endif

// [usfc_pkg.sv]
// types for the serial receive flow-control block
package usfc_pkg;
   typedef enum logic [1:0] {
      USFC_MODE_NORMAL = 2'b00,
      USFC_MODE_HWHS = 2'b01,
      USFC_MODE_SPI_SLAVE = 2'b10,
      USFC_MODE_ISO_T1 = 2'b11
   } usfc_mode_t;
endpackage

// [usfc_fifo.sv]
// small receive fifo between the shifter and the dma side
`timescale 1ns/1ps
module usfc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o,
   output logic full_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   wire [AW-1:0] wr_nx = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
   wire [AW-1:0] rd_nx = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
   // head word and valid are kept in flops so the dma side sees register outputs
   logic valid_q;
   logic [W-1:0] head_q;
   wire [AW:0] cnt_nx = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   wire head_from_in = pop ? (cnt_q == (AW+1)'(1)) : (cnt_q == '0);
   wire [W-1:0] head_pick = pop ? mem_q[rd_nx] : head_q;
   wire [W-1:0] head_nx = head_from_in ? in_data_i : head_pick;

   assign full_o = (cnt_q == (AW+1)'(DEPTH));
   assign in_ready_o = !full_o;
   assign out_valid_o = valid_q;
   assign out_data_o = head_q;

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         valid_q <= 1'b0;
         head_q <= '0;
      end else if (flush_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         valid_q <= 1'b0;
         head_q <= '0;
      end else begin
         if (push) wr_q <= wr_nx;
         if (pop) rd_q <= rd_nx;
         cnt_q <= cnt_nx;
         valid_q <= (cnt_nx != '0);
         head_q <= head_nx;
      end
   end
endmodule

// [usfc_peer_model.sv]
// remote serial peer: drives external clock, data and select pins
`timescale 1ns/1ps
module usfc_peer_model #(
   parameter int HALF = 5
) (
   input wire logic clk_sys_i,
   output logic ser_clk_o,
   output logic ser_data_o,
   output logic sel_n_o
);
   // clock stands low outside frames, select idles high
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b1;
      sel_n_o = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #2;
   endtask
   // lsb first; period of 2*HALF core clocks keeps the clock under a ninth
   task automatic send(input logic [15:0] data, input int nbits);
      step(1);
      sel_n_o = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         ser_data_o = data[i];
         step(HALF);
         ser_clk_o = 1'b1;
         step(HALF);
         ser_clk_o = 1'b0;
      end
      // released line must not keep showing the last bit
      ser_data_o = ~ser_data_o;
      sel_n_o = 1'b1;
      step(HALF);
   endtask
endmodule

// [tb_top.sv]
// self-checking bench for the receive flow-control block
`timescale 1ns/1ps
module tb_top;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] mode = 2'b00;
   logic [5:0] cmd = 6'h00;
   logic buf_full = 1'b0;
   logic dma_ready = 1'b0;
   logic ser_clk, ser_data, sel_n;
   logic [7:0] dma_data;
   logic [7:0] d;
   logic dma_valid, rts, rx_en, len_err;
   logic [7:0] exp_q [$];
   int n_errors = 0;
   int n_compared = 0;
   int unsigned seed_v;
   always #10 clk_sys_i = ~clk_sys_i;
   usfc_peer_model peer_i (.clk_sys_i(clk_sys_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
      .sel_n_o(sel_n));
   usfc_top usfc_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .mode_config_reg_i(mode),
      .rx_enable_cmd_i(cmd[0]), .rx_soft_reset_cmd_i(cmd[1]), .rts_force_high_cmd_i(cmd[2]),
      .rts_force_low_cmd_i(cmd[3]), .len_err_clear_i(cmd[4]), .serial_clk_i(ser_clk),
      .serial_data_i(ser_data), .spi_sel_n_i(sel_n), .dma_buf_full_i(buf_full),
      .dma_buf_avail_i(cmd[5]), .dma_ready_i(dma_ready), .dma_data_o(dma_data),
      .dma_valid_o(dma_valid), .rts_o(rts), .rx_enabled_o(rx_en), .len_err_o(len_err));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [7:0] char_of(input logic [15:0] bits);
      return bits[7:0];
   endfunction
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #2;
   endtask
   task automatic pulse(input logic [5:0] v);
      cmd = v;
      cyc(1);
      cmd = 6'h00;
      cyc(1);
   endtask
   task automatic wait_pop(input logic [7:0] exp);
      for (int k = 0; k < 60 && dma_valid !== 1'b1; k++) cyc(1);
      // a wait that runs out is counted here, not hidden behind stale data
      chk("dma_valid", dma_valid, 1'b1);
      chk("dma_data", dma_data, exp);
      dma_ready = 1'b1;
      cyc(1);
      dma_ready = 1'b0;
      cyc(1);
   endtask
   task automatic rx_one(input logic [7:0] v, input int nbits);
      peer_i.send({8'h00, v}, nbits);
      wait_pop(char_of({8'h00, v}));
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      #200_000;
      n_errors++;
      end_sim();
   end
   initial begin
      seed_v = $urandom(32'h75842a40);
      cyc(10);
      rst_i = 1'b0;
      cyc(3);
      chk("rts_rst", rts, 1'b1);
      chk("rx_en_rst", rx_en, 1'b0);
      pulse(6'h08);
      chk("rts_low", rts, 1'b0);
      pulse(6'h04);
      chk("rts_high", rts, 1'b1);
      pulse(6'h08);
      pulse(6'h0C);
      chk("rts_both", rts, 1'b1);
      pulse(6'h01);
      chk("rx_en", rx_en, 1'b1);
      rx_one(8'h00, 8);
      rx_one(8'hFF, 8);
      rx_one(8'($urandom), 8);
      // handshaking: dma buffer full, then fifo full with a fifth char dropped
      mode = usfc_pkg::USFC_MODE_HWHS;
      pulse(6'h08);
      buf_full = 1'b1;
      cyc(2);
      chk("rts_dma_full", rts, 1'b1);
      buf_full = 1'b0;
      pulse(6'h20);
      chk("rts_avail", rts, 1'b0);
      for (int i = 0; i < 5; i++) begin
         d = 8'($urandom);
         if (i < 4) exp_q.push_back(d);
         peer_i.send({8'h00, d}, 8);
      end
      cyc(8);
      chk("rts_fifo_full", rts, 1'b1);
      while (exp_q.size() > 0) wait_pop(exp_q.pop_front());
      cyc(2);
      chk("dma_valid_empty", dma_valid, 1'b0);
      pulse(6'h20);
      chk("rts_resume", rts, 1'b0);
      // spi slave: eight bits clean, nine bits flagged
      mode = usfc_pkg::USFC_MODE_SPI_SLAVE;
      rx_one(8'($urandom), 8);
      chk("len_err_8", len_err, 1'b0);
      peer_i.send(16'h01A5, 9);
      cyc(2);
      chk("len_err_9", len_err, 1'b1);
      pulse(6'h10);
      chk("len_err_clr", len_err, 1'b0);
      // iso t1: soft reset and re-enable restore reception
      mode = usfc_pkg::USFC_MODE_ISO_T1;
      pulse(6'h02);
      chk("rx_en_soft", rx_en, 1'b0);
      chk("valid_soft", dma_valid, 1'b0);
      pulse(6'h01);
      rx_one(8'($urandom), 8);
      end_sim();
   end
endmodule
